// ==== hw/adc_dc_highpass_filter.sv ====
`timescale 1ns/1ps

// Overview of operation
// RULE_01: enable bit 0, set after reset
// RULE_02: host keeps filter on with level_compressor
// RULE_03: bit 6 picks first or second order
// RULE_04: bits 5:4 rate band, reset 10
// RULE_05: host matches band to adc rate
// RULE_06: hi-fi corner 3.5 Hz at 44.1k
// RULE_07: bits 3:1 corner code, application only
// RULE_08: corner scales with sample rate
// RULE_09: host picks voice corner below 300 Hz
// RULE_10: application corners rise with code
// RULE_11: disabled path passes samples, same latency
module adc_dc_highpass_filter
#(
  parameter int DATA_W     = 16,
  parameter int FIFO_DEPTH = hpf_pkg::FIFO_DEPTH
)
(
  input  wire logic              mclk,       // audio sample clock
  input  wire logic              rst,        // async reset, high
  input  wire logic              reg_wr,     // register write strobe
  input  wire logic              reg_rd,     // register read strobe
  input  wire logic [6:0]        reg_addr,   // register index
  input  wire logic [15:0]       reg_wdata,  // write data
  output      logic [15:0]       reg_rdata,  // read data, one cycle after
  input  wire logic              in_valid,   // adc sample present
  output      logic              in_ready,   // filter takes sample
  input  wire logic [DATA_W-1:0] in_data,    // adc sample, signed
  output      logic              out_valid,  // filtered sample present
  input  wire logic              out_ready,  // dsp chain takes sample
  output      logic [DATA_W-1:0] out_data    // filtered sample, signed
);

  localparam int ACC_W = DATA_W + 24;  // state width, FRAC_W fraction bits
  localparam int FW    = hpf_pkg::FRAC_W;
  localparam int CW    = hpf_pkg::COEF_W;

  initial
  begin
    if (DATA_W < 8 || DATA_W > 32 || FIFO_DEPTH < 4)
      $error("adc_dc_highpass_filter: unsupported width or depth");
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [hpf_pkg::CTRL_BITS-1:0] ctrl_q;
  logic [15:0]                   rdata_q;

  wire ctrl_hit = reg_addr == hpf_pkg::CTRL_ADDR;

  // write and reset value of the control word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctrl_q <= hpf_pkg::CTRL_RESET;                   // RULE_01
    else if (reg_wr && ctrl_hit)
      ctrl_q <= reg_wdata[hpf_pkg::CTRL_BITS-1:0];
  end

  // read path, reserved bits and other indices read zero
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_q <= '0;
    else if (reg_rd)
      rdata_q <= ctrl_hit ? {9'h000, ctrl_q} : 16'h0000;
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // field decode and coefficient selection
  // ----------------------------------------------------------------
  wire                      filt_en    = ctrl_q[hpf_pkg::ENABLE_BIT];                   // RULE_01
  wire                      second_ord = ctrl_q[hpf_pkg::ORDER_BIT];                    // RULE_03
  wire [1:0]                band_raw   = ctrl_q[hpf_pkg::BAND_MSB:hpf_pkg::BAND_LSB];   // RULE_04
  wire [2:0]                code       = ctrl_q[hpf_pkg::CODE_MSB:hpf_pkg::CODE_LSB];   // RULE_07
  // reserved band behaves as the top band
  wire [1:0]                band       = (band_raw == hpf_pkg::BAND_RESERVED)
                                         ? hpf_pkg::BAND_32K_48K : band_raw;
  wire [4:0]                app_idx    = 5'(band) * 5'd8 + 5'(code);
  wire [CW-1:0]             hifi_coef  = hpf_pkg::HIFI_COEF[band];                     // RULE_06
  wire [CW-1:0]             app_coef   = hpf_pkg::APP_COEF[app_idx];                   // RULE_10
  // code has no say in hi-fi mode
  wire [CW-1:0]             coef       = second_ord ? app_coef : hifi_coef;            // RULE_07

  // ----------------------------------------------------------------
  // datapath arithmetic
  // ----------------------------------------------------------------
  function automatic logic signed [ACC_W-1:0] leak
  (
    input logic signed [ACC_W-1:0] v,
    input logic [CW-1:0]           c
  );
    logic signed [ACC_W+CW:0] p;
    p    = v * $signed({1'b0, c});
    leak = p[ACC_W+FW-1:FW];
  endfunction

  function automatic logic [DATA_W-1:0] saturate
  (
    input logic signed [ACC_W-1:0] v
  );
    logic signed [ACC_W-FW-1:0] w;
    w = v[ACC_W-1:FW];
    if (w > $signed((ACC_W-FW)'({1'b0, {(DATA_W-1){1'b1}}})))
      saturate = {1'b0, {(DATA_W-1){1'b1}}};
    else if (w < -$signed((ACC_W-FW)'({1'b0, {(DATA_W-1){1'b1}}})) - 1)
      saturate = {1'b1, {(DATA_W-1){1'b0}}};
    else
      saturate = w[DATA_W-1:0];
  endfunction

  logic signed [ACC_W-1:0] x1_q;
  logic signed [ACC_W-1:0] y1_q;
  logic signed [ACC_W-1:0] x2_q;
  logic signed [ACC_W-1:0] y2_q;
  logic                    push_q;
  logic [DATA_W-1:0]       push_data_q;
  logic                    fifo_ready;

  // one first-order section: y = x - x1 + y1 - c*y1
  wire signed [ACC_W-1:0] x_ext = ACC_W'($signed(in_data)) <<< FW;
  wire signed [ACC_W-1:0] s1    = x_ext - x1_q + y1_q - leak(y1_q, coef);       // RULE_08
  wire signed [ACC_W-1:0] s2    = s1 - x2_q + y2_q - leak(y2_q, coef);          // RULE_03
  wire signed [ACC_W-1:0] s_out = second_ord ? s2 : s1;
  wire                    take  = in_valid && fifo_ready;
  // disabled path takes the same register stage, unmodified
  wire [DATA_W-1:0]       y_d   = filt_en ? saturate(s_out) : in_data;          // RULE_11

  assign in_ready = fifo_ready;

  // ----------------------------------------------------------------
  // filter state, cleared by each sample taken while off so enabling starts clean
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      x1_q <= '0;
      y1_q <= '0;
    end
    else if (take)
    begin
      x1_q <= filt_en ? x_ext : '0;                    // RULE_01
      y1_q <= filt_en ? s1 : '0;
    end
  end

  // second section only runs in application mode
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      x2_q <= '0;
      y2_q <= '0;
    end
    else if (take)
    begin
      x2_q <= (filt_en && second_ord) ? s1 : '0;       // RULE_03
      y2_q <= (filt_en && second_ord) ? s2 : '0;
    end
  end

  // one-cycle output stage into the buffer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      push_q      <= 1'b0;
      push_data_q <= '0;
    end
    else
    begin
      push_q      <= take;                             // RULE_11
      push_data_q <= take ? y_d : push_data_q;
    end
  end

  // ----------------------------------------------------------------
  // output buffer toward the dsp chain
  // ----------------------------------------------------------------
  sample_fifo
  #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH),
    .SLACK (hpf_pkg::FIFO_SLACK)
  )
  u_fifo
  (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (fifo_ready),
    .in_data   (push_data_q),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire [CW-1:0] app_next  = hpf_pkg::APP_COEF[5'(band) * 5'd8 + 5'(code) + 5'd1];
  wire [CW-1:0] app_low   = hpf_pkg::APP_COEF[5'(code)];
  wire [CW-1:0] app_high  = hpf_pkg::APP_COEF[5'd16 + 5'(code)];

  sequence bypass_take;
    take && !filt_en;
  endsequence

  sequence bypass_push(logic [DATA_W-1:0] d);
    push_q && push_data_q == d;
  endsequence

  a_reset_control: assert property (@(posedge mclk) $fell(rst) |-> ctrl_q == hpf_pkg::CTRL_RESET) // RULE_01
    else $error("control word wrong after reset");

  a_ctrl_write: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    reg_wr && ctrl_hit |=> ctrl_q == $past(reg_wdata[hpf_pkg::CTRL_BITS-1:0]))
    else $error("control write not stored");

  a_bypass_exact: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    bypass_take |=> bypass_push($past(in_data)))
    else $error("disabled path changed the sample");

  a_order_first: assert property (@(posedge mclk) disable iff (rst) // RULE_03
    take && !second_ord |=> x2_q == '0 && y2_q == '0)
    else $error("second section ran in hi-fi mode");

  a_band_reset: assert property (@(posedge mclk) $fell(rst) |-> band_raw == 2'b10) // RULE_04
    else $error("rate band wrong after reset");

  a_hifi_corner: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    !second_ord && band == hpf_pkg::BAND_32K_48K |-> coef == 16'h0021)
    else $error("hi-fi corner coefficient wrong");

  a_code_ignored: assert property (@(posedge mclk) disable iff (rst) // RULE_07
    !second_ord && $stable(second_ord) && $changed(code) && $stable(band) |-> $stable(coef))
    else $error("corner code acted in hi-fi mode");

  a_corner_rise: assert property (@(posedge mclk) disable iff (rst) // RULE_10
    second_ord && code != 3'd7 |-> app_next > coef)
    else $error("corners not rising with code");

  // four times the rate, a quarter of the step, within the rounding of the corners
  a_rate_scale: assert property (@(posedge mclk) disable iff (rst) // RULE_08
    second_ord |-> app_low > app_high && app_low[CW-1:2] <= app_high + (app_high >> 5)
                   && app_high <= app_low[CW-1:2] + (app_low[CW-1:2] >> 5))
    else $error("corner not scaled with rate band");

  // ----------------------------------------------------------------
  // bus and stream checks
  // ----------------------------------------------------------------
  sequence sample_taken;
    take;
  endsequence

  a_read_ctrl: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    reg_rd && ctrl_hit |=> reg_rdata == {9'h000, $past(ctrl_q)})
    else $error("control read data wrong");

  a_read_other: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    reg_rd && !ctrl_hit |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");

  a_read_hold: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without strobe");

  a_reset_outputs: assert property (@(posedge mclk) // RULE_01
    $fell(rst) |-> !out_valid && !in_ready && reg_rdata == 16'h0000)
    else $error("outputs not idle after reset");

  a_ready_after_reset: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    $fell(rst) |=> in_ready)
    else $error("input not ready after reset");

  a_stage_latency: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    sample_taken |=> push_q)
    else $error("taken sample not staged next cycle");

  a_stage_source: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    push_q |-> $past(take))
    else $error("staged sample without a take");

  a_state_cleared: assert property (@(posedge mclk) disable iff (rst) // RULE_01
    take && !filt_en |=> x1_q == '0 && y1_q == '0 && x2_q == '0 && y2_q == '0)
    else $error("filter state kept while disabled");

  a_band_reserved: assert property (@(posedge mclk) disable iff (rst) // RULE_04
    band_raw == 2'b11 && second_ord |-> coef == hpf_pkg::APP_COEF[5'd16 + 5'(code)])
    else $error("reserved band not served as top band");

  a_out_held: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output sample dropped before taken");

  // with clean state either order hands the first sample through unchanged
  a_clean_start: assert property (@(posedge mclk) disable iff (rst) // RULE_06
    take && filt_en && x1_q == '0 && y1_q == '0 && x2_q == '0 && y2_q == '0
    |=> bypass_push($past(in_data)))
    else $error("first sample after clear altered");

endmodule

// ==== include/hpf_pkg.sv ====
package hpf_pkg;

  // ----------------------------------------------------------------
  // control register map
  // ----------------------------------------------------------------
  localparam logic [6:0]  CTRL_ADDR        = 7'h1a;  // control register index
  localparam int          CTRL_BITS        = 7;      // implemented low bits
  localparam logic [6:0]  CTRL_RESET       = 7'h21;  // enable=1 band=10 code=000 order=0
  localparam int          ENABLE_BIT       = 0;
  localparam int          CODE_LSB         = 1;
  localparam int          CODE_MSB         = 3;
  localparam int          BAND_LSB         = 4;
  localparam int          BAND_MSB         = 5;
  localparam int          ORDER_BIT        = 6;

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    BAND_8K_12K   = 2'b00,
    BAND_16K_24K  = 2'b01,
    BAND_32K_48K  = 2'b10,
    BAND_RESERVED = 2'b11
  } rate_band_type;

  // ----------------------------------------------------------------
  // leak coefficients, Q16: c = 2*pi*fc/fs per section
  // ----------------------------------------------------------------
  localparam int COEF_W   = 16;  // coefficient width
  localparam int FRAC_W   = 16;  // fractional bits of the state
  localparam int CODE_NUM = 8;   // corner codes per band

  // hi-fi, one section: 3.0 Hz at 8k, 3.0 Hz at 16k, 3.5 Hz at 44.1k
  localparam logic [COEF_W-1:0] HIFI_COEF [0:2] = '{16'h009a, 16'h004d, 16'h0021};

  // application, two equal sections, -3 dB point at the listed corner
  localparam logic [COEF_W-1:0] APP_COEF [0:23] = '{
    16'h1926, 16'h1f65, 16'h284d, 16'h3224, 16'h3ea3, 16'h5021, 16'h6420, 16'h7d1e,
    16'h0c7f, 16'h0fc7, 16'h1427, 16'h1926, 16'h1f52, 16'h2811, 16'h3225, 16'h3ea4,
    16'h0640, 16'h07ed, 16'h0a13, 16'h0c89, 16'h0f9f, 16'h141c, 16'h18fd, 16'h1f51};

  // ----------------------------------------------------------------
  // stream buffer
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;  // output buffer words
  localparam int FIFO_SLACK = 2;   // free words kept before ready falls

endpackage

// ==== hw/sample_fifo.sv ====
`timescale 1ns/1ps

module sample_fifo
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32,
  parameter int SLACK = 2
)
(
  input  wire logic             mclk,      // audio clock
  input  wire logic             rst,       // async reset, high
  input  wire logic             in_valid,  // push request
  output      logic             in_ready,  // room for SLACK more words
  input  wire logic [WIDTH-1:0] in_data,   // pushed word
  output      logic             out_valid, // head word present
  input  wire logic             out_ready, // consumer takes head
  output      logic [WIDTH-1:0] out_data   // head word
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 4 || (1 << AW) != DEPTH || SLACK < 1 || SLACK >= DEPTH)
      $error("sample_fifo: depth must be a power of two >= 4, slack in range");
  end

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             ready_q;
  logic             head_valid_q;
  logic [WIDTH-1:0] head_q;

  // ----------------------------------------------------------------
  // flow decode
  // ----------------------------------------------------------------
  wire push     = in_valid && (count_q != (AW+1)'(DEPTH));
  wire can_pop  = count_q != '0;
  wire load_out = can_pop && (!head_valid_q || out_ready);
  wire drop_out = head_valid_q && out_ready && !can_pop;

  assign count_d   = count_q + (AW+1)'(push) - (AW+1)'(load_out);
  assign in_ready  = ready_q;
  assign out_valid = head_valid_q;
  assign out_data  = head_q;

  // storage write
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr_q] <= in_data;
  end

  // pointers and level
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      ready_q  <= 1'b0;
    end
    else
    begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(load_out);
      count_q  <= count_d;
      ready_q  <= count_d <= (AW+1)'(DEPTH - SLACK);
    end
  end

  // registered head word
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      head_valid_q <= 1'b0;
      head_q       <= '0;
    end
    else if (load_out)
    begin
      head_valid_q <= 1'b1;
      head_q       <= mem[rd_ptr_q];
    end
    else if (drop_out)
      head_valid_q <= 1'b0;
  end

  // slack must cover the staged word, a push never meets a full store
  a_fifo_room: assert property (@(posedge mclk) disable iff (rst) // RULE_11
    in_valid |-> count_q != (AW+1)'(DEPTH))
    else $error("push met a full buffer");

endmodule

// ==== tb/hpf_stream_model.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// adc source and dsp sink model
// ----------------------------------------------------------------
module hpf_stream_model
(
  input  wire logic        mclk,      // audio clock
  input  wire logic        src_en,    // source may offer samples
  input  wire logic        dc_mode,   // offer a constant value
  input  wire logic [15:0] dc_value,  // constant sample
  input  wire logic [1:0]  stall,     // 0 none, 1 random, 2 full
  input  wire logic        in_ready,  // filter takes sample
  output      logic        in_valid,  // sample offered
  output      logic [15:0] in_data,   // offered sample
  output      logic        out_ready  // sink takes sample
);
  integer seed = 1;
  logic   hold;
  logic   en;
  logic   dc;

  initial
  begin
    in_valid = 1'b0;
    in_data = 16'h0000;
    out_ready = 1'b0;
  end

  // offer held until taken, idle data toggles so nothing stale is seen
  always @(posedge mclk)
  begin
    hold = in_valid && !in_ready;
    en = src_en;
    dc = dc_mode;
    #1;
    if (!hold)
    begin
      in_valid = en;
      in_data = !en ? ~in_data : dc ? dc_value : 16'($random(seed));
    end
    out_ready = (stall == 2'd0) ? 1'b1 : (stall == 2'd2) ? 1'b0 : 1'($random(seed) & 1);
  end
endmodule

// ==== tb/adc_dc_highpass_filter_test.sv ====
`timescale 1ns/1ps

module adc_dc_highpass_filter_test;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [6:0]  reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata, in_data, out_data, rv, wv;
  logic        in_valid, in_ready, out_valid, out_ready;
  logic        src_en = 1'b0;
  logic        dc_mode = 1'b0;
  logic [15:0] dc_value = 16'h2000;
  logic [1:0]  stall = 2'd0;
  logic        pass_chk = 1'b0;
  logic [15:0] expq [$];
  logic [15:0] log_q [0:63];
  integer      num_errors = 0, comparisons = 0, seed = 1;
  integer      cyc = 0, takes = 0, outs = 0, t_in = 0, t_out = 0, i, s0, s5, s7, sh;

  always #2.5 mclk = ~mclk;

  adc_dc_highpass_filter u_dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_ready(in_ready), .in_data(in_data), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data));

  hpf_stream_model u_model (.mclk(mclk), .src_en(src_en), .dc_mode(dc_mode),
    .dc_value(dc_value), .stall(stall), .in_ready(in_ready), .in_valid(in_valid),
    .in_data(in_data), .out_ready(out_ready));

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // accepted samples queued, delivered samples logged, and compared while pass_chk is set
  always @(posedge mclk)
  begin
    cyc++;
    if (in_valid && in_ready)
    begin
      if (takes == 0)
        t_in = cyc;
      expq.push_back(in_data);
      takes++;
    end
    if (out_valid && out_ready)
    begin
      if (outs == 0)
        t_out = cyc;
      wv = expq.pop_front();
      if (pass_chk)
        check("passthrough", wv, out_data);
      if (outs < 64)
        log_q[outs] = out_data;
      outs++;
    end
  end

  function automatic logic [15:0] exp_ctrl(input logic [15:0] d);
    return {9'h000, d[6:0]};
  endfunction

  function automatic integer absum;
    integer s = 0;
    for (int k = 0; k < 40; k++)
      s += ($signed(log_q[k]) < 0) ? -$signed(log_q[k]) : $signed(log_q[k]);
    return s;
  endfunction

  task automatic do_reset;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge mclk);
    #1 reg_rd = 1'b0;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask

  // one stream run from a fresh state, full stall first fills the buffer
  task automatic run(input logic [15:0] ctrl, input integer n, input logic dc,
                     input logic [1:0] stl);
    integer k;
    do_reset();
    takes = 0;
    outs = 0;
    expq.delete();
    wr(7'h1a, ctrl);
    dc_mode = dc;
    stall = stl;
    src_en = 1'b1;
    for (k = 0; k < 1000 && takes < n; k++)
      @(posedge mclk);
    #1 src_en = 1'b0;
    if (stl != 2'd2)
      check("source", 32'd1, {31'd0, takes >= n});
    if (stl == 2'd2)
    begin
      check("fill refused", 32'd0, {31'd0, in_ready});
      check("fill count", 32'd1, {31'd0, takes >= hpf_pkg::FIFO_DEPTH - hpf_pkg::FIFO_SLACK
            && takes <= hpf_pkg::FIFO_DEPTH + 1});
      stall = 2'd1;
    end
    for (k = 0; k < 2000 && outs < takes; k++)
      @(posedge mclk);
    #1;
    check("drained", takes, outs);
    if (outs < takes)
      final_report();
    if (stl == 2'd0)
      check("latency", 32'd3, t_out - t_in);
  endtask

  initial
  begin
    do_reset();
    rd(7'h1a, rv);
    check("ctrl reset", 32'h0021, rv);
    wr(7'h1a, 16'hffff);
    rd(7'h1a, rv);
    check("ctrl ones", 32'h007f, rv);
    wr(7'h1b, 16'h0000);
    rd(7'h1b, rv);
    check("unmapped", 32'h0000, rv);
    rd(7'h1a, rv);
    check("ctrl kept", 32'h007f, rv);
    for (i = 0; i < 6; i++)
    begin
      wv = 16'($random(seed));
      wr(7'h1a, wv);
      rd(7'h1a, rv);
      check("ctrl random", exp_ctrl(wv), rv);
    end
    $display("test registers done");
    pass_chk = 1'b1;
    run(16'h0020, 200, 1'b0, 2'd1);
    run(16'h0020, 20, 1'b0, 2'd0);
    run(16'h0020, 40, 1'b0, 2'd2);
    $display("test bypass done");
    pass_chk = 1'b0;
    run(16'h0021, 40, 1'b1, 2'd0);
    check("hifi first", dc_value, log_q[0]);
    sh = absum();
    check("hifi bass", 32'd1, {31'd0, sh > 30 * 8192});
    run(16'h002f, 40, 1'b1, 2'd0);
    check("hifi code", sh, absum());
    run(16'h0041, 40, 1'b1, 2'd0);
    s0 = absum();
    check("app order", 32'd1, {31'd0, s0 < sh});
    run(16'h004b, 40, 1'b1, 2'd0);
    s5 = absum();
    run(16'h004f, 40, 1'b1, 2'd0);
    s7 = absum();
    check("app corners", 32'd1, {31'd0, s0 > s5 && s5 > s7});
    run(16'h0061, 40, 1'b1, 2'd0);
    check("band scale", 32'd1, {31'd0, absum() > s0});
    $display("test filter done");
    final_report();
  end
endmodule
